// File: src/rcsd_top.sv
`timescale 1ns/1ps
`default_nettype none
module rcsd_top
  import rcsd_pkg::*;
#(
  parameter int BRIGHT_LEVELS = 26
) (
  // apb slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // receiver side
  input  wire logic                   rx_clean,
  input  wire logic                   rx_pulse,
  input  wire logic                   rx_minute_mark,
  input  wire logic                   sec_tick,
  // buttons, levels, high while pressed
  input  wire logic                   btn_plus,
  input  wire logic                   btn_minus,
  input  wire logic                   btn_step,
  // display
  output logic                        rx_led,
  output logic                        disp_blank,
  output logic                        disp_dp,
  output rcsd_pkg::rcsd_content_t     disp_content,
  output rcsd_pkg::rcsd_sync_t        disp_status,
  output logic [rcsd_pkg::RCSD_BW-1:0] disp_bright,
  output logic                        alarm_on,
  output logic [rcsd_pkg::RCSD_MW-1:0] menu_main,
  output logic [rcsd_pkg::RCSD_MW-1:0] menu_item,
  output logic                        menu_in_sub
);
  import rcsd_pkg::*;

  // ==========================================
  // parameter check
  // elaboration stops on a level count the clamp cannot serve
  if (BRIGHT_LEVELS != int'(RCSD_BRIGHT_FULL) + 1) begin : g_bad_levels
    $error("brightness levels must match the full-level code");
  end

  // ==========================================
  // declarations
  logic [RCSD_BW-1:0] rx_bright;
  rcsd_mode_t         disp_mode;
  logic               led_en;
  logic               temp_active;
  logic [7:0]         alt_secs;
  logic [RCSD_BW-1:0] bright;
  rcsd_sync_t         sync_state;
  rcsd_sync_t         next_sync_state;
  logic [5:0]         sec_count;
  logic [5:0]         next_sec_count;
  logic               flash;
  logic [7:0]         alt_count;
  logic               alt_date;
  logic [3:0]         btn_rise;
  logic               plus_hit;
  logic               minus_hit;
  logic               step_hit;
  logic               pulse_hit;

  // ==========================================
  // button and pulse edges
  rcsd_edge #(
    .N (4)
  ) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   ({rx_pulse, btn_step, btn_minus, btn_plus}),
    .rise    (btn_rise)
  );
  assign plus_hit  = btn_rise[0];
  assign minus_hit = btn_rise[1];
  assign step_hit  = btn_rise[2];
  assign pulse_hit = btn_rise[3];

  // ==========================================
  // apb decode
  wire apb_acc   = psel & penable;
  wire hit_ctrl  = (paddr == RCSD_OFF_CTRL);
  wire hit_brt   = (paddr == RCSD_OFF_BRIGHT);
  wire hit_st    = (paddr == RCSD_OFF_STATUS);
  wire addr_ok   = hit_ctrl | hit_brt | hit_st;
  wire wr_ctrl   = apb_acc & pwrite & hit_ctrl;
  wire wr_brt    = apb_acc & pwrite & hit_brt;
  // the status word is read-only; a write to it is refused
  wire bad_acc   = ~addr_ok | (pwrite & hit_st);
  // out-of-range levels are clamped so the display never overdrives
  wire [RCSD_BW-1:0] wr_level = pwdata[RCSD_BW-1:0];
  wire [RCSD_BW-1:0] level_ok =
    (wr_level > RCSD_BRIGHT_FULL) ? RCSD_BRIGHT_FULL : wr_level;
  wire [RCSD_BW-1:0] rxb_raw  = pwdata[RCSD_CTRL_RXB_LSB +: RCSD_BW];
  wire [RCSD_BW-1:0] rxb_ok   =
    (rxb_raw > RCSD_BRIGHT_FULL) ? RCSD_BRIGHT_FULL : rxb_raw;

  wire [31:0] ctrl_word = {8'h00, alt_secs, 7'h00, temp_active, led_en,
                           disp_mode, rx_bright};
  wire [31:0] brt_word  = {27'h0000000, bright};
  wire [31:0] st_word   = {2'h0, sec_count, 3'h0, disp_bright, 3'h0,
                           menu_in_sub, menu_item, menu_main, flash,
                           alarm_on, sync_state};
  wire [31:0] rd_word   = hit_ctrl ? ctrl_word :
                          hit_brt  ? brt_word  :
                          hit_st   ? st_word   : 32'h00000000;

  // ==========================================
  // apb answer, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & bad_acc;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  // writes take effect on the access edge where pready is high
  wire do_wr_ctrl = wr_ctrl & pready;
  wire do_wr_brt  = wr_brt & pready;

  // ==========================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bright   <= RCSD_RST_RXBRIGHT;
      disp_mode   <= show_alternating_mode;
      led_en      <= 1'b1;
      temp_active <= 1'b0;
      alt_secs    <= RCSD_RST_ALT_SECS;
    end else if (do_wr_ctrl) begin
      rx_bright   <= rxb_ok;
      disp_mode   <= rcsd_mode_t'(pwdata[RCSD_CTRL_MODE_LSB +: 2]);
      led_en      <= pwdata[RCSD_CTRL_LED_BIT];
      temp_active <= pwdata[RCSD_CTRL_TEMP_BIT];
      alt_secs    <= pwdata[RCSD_CTRL_ALT_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bright <= RCSD_RST_BRIGHT;
    end else if (do_wr_brt) begin
      bright <= level_ok;
    end
  end

  // ==========================================
  // synchronisation sequence
  always_comb begin
    next_sync_state = sync_state;
    next_sec_count  = sec_count;
    unique case (sync_state)
      rcsd_no_signal: begin
        if (rx_clean) begin
          next_sync_state = rcsd_searching;
        end
      end
      rcsd_searching: begin
        if (!rx_clean) begin
          next_sync_state = rcsd_no_signal;
        end else if (rx_minute_mark) begin
          next_sync_state = status_decoding;
          next_sec_count  = 6'h00;
        end
      end
      status_decoding: begin
        if (!rx_clean) begin
          next_sync_state = rcsd_no_signal;
        end else if (pulse_hit) begin
          // a full minute of seconds must arrive before time is trusted
          if (next_sec_count == 6'(RCSD_READ_SECONDS - 1)) begin
            next_sync_state = rcsd_synced;
            next_sec_count  = 6'h00;
          end else begin
            next_sec_count = sec_count + 6'h01;
          end
        end
      end
      rcsd_synced: begin
        // once synced the clock free-runs; losing the signal is harmless
        next_sync_state = rcsd_synced;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_state <= rcsd_no_signal;
      sec_count  <= 6'h00;
    end else begin
      sync_state <= next_sync_state;
      sec_count  <= next_sec_count;
    end
  end

  wire syncing = (sync_state != rcsd_synced);

  // ==========================================
  // menu navigation
  function automatic logic [3:0] sub_items(input logic [3:0] entry);
    logic [3:0] n;
    n = 4'h0;
    if (entry == RCSD_MAIN_ALARM)  n = RCSD_ITEMS_ALARM;
    if (entry == RCSD_MAIN_BRIGHT) n = RCSD_ITEMS_BRIGHT;
    if (entry == RCSD_MAIN_DCF)    n = RCSD_ITEMS_DCF;
    if (entry == RCSD_MAIN_CLOCK)  n = RCSD_ITEMS_CLOCK;
    return n;
  endfunction : sub_items

  wire [3:0] cur_items  = sub_items(menu_main);
  wire       in_normal  = (menu_main == RCSD_MAIN_NORMAL) & ~menu_in_sub;
  wire       main_last  = (menu_main == 4'(RCSD_MAIN_ENTRIES - 1));
  wire       item_last  = (menu_item == cur_items - 4'h1);
  wire       can_enter  = (cur_items != 4'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_main   <= RCSD_MAIN_NORMAL;
      menu_item   <= 4'h0;
      menu_in_sub <= 1'b0;
    end else if (menu_in_sub) begin
      if (step_hit) begin
        menu_item <= item_last ? 4'h0 : menu_item + 4'h1;
      end else if (minus_hit) begin
        menu_in_sub <= 1'b0;
        menu_item   <= 4'h0;
      end
    end else if (step_hit) begin
      menu_main <= main_last ? RCSD_MAIN_NORMAL : menu_main + 4'h1;
    end else if (plus_hit & can_enter) begin
      menu_in_sub <= 1'b1;
      menu_item   <= 4'h0;
    end
  end

  // ==========================================
  // normal-mode buttons
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_on <= 1'b0;
      flash    <= 1'b0;
    end else begin
      if (in_normal & plus_hit) begin
        alarm_on <= ~alarm_on;
      end
      // flashlight is a toggle; leaving normal mode switches it off
      if (!in_normal) begin
        flash <= 1'b0;
      end else if (minus_hit) begin
        flash <= ~flash;
      end
    end
  end

  // ==========================================
  // time/date alternation
  wire alt_wrap = (alt_count + 8'h01 >= alt_secs);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_count <= 8'h00;
      alt_date  <= 1'b0;
    end else if (disp_mode != show_alternating_mode) begin
      alt_count <= 8'h00;
      alt_date  <= 1'b0;
    end else if (sec_tick) begin
      alt_count <= alt_wrap ? 8'h00 : alt_count + 8'h01;
      alt_date  <= alt_wrap ? ~alt_date : alt_date;
    end
  end

  // ==========================================
  // display selection
  rcsd_content_t      mode_content;
  rcsd_content_t      next_content;
  logic               next_blank;
  logic               next_dp;
  logic [RCSD_BW-1:0] next_bright;

  always_comb begin
    unique case (disp_mode)
      show_nothing_mode: begin
        mode_content = temp_active ? rcsd_show_temp : rcsd_show_dashes;
      end
      show_time_only_mode: begin
        mode_content = rcsd_show_time;
      end
      show_date_only_mode: begin
        mode_content = rcsd_show_date;
      end
      show_alternating_mode: begin
        mode_content = alt_date ? rcsd_show_date : rcsd_show_time;
      end
    endcase
  end

  always_comb begin
    next_content = mode_content;
    next_blank   = 1'b0;
    next_dp      = 1'b0;
    next_bright  = bright;
    if (!in_normal) begin
      next_content = rcsd_show_menu;
    end else if (syncing && rx_bright != RCSD_BRIGHT_OFF) begin
      // dimmer display keeps multiplex noise away from the antenna
      next_content = rcsd_show_status;
      next_bright  = rx_bright;
    end else if (syncing) begin
      next_content = rcsd_show_status;
      next_blank   = 1'b1;
      next_dp      = 1'b1;
      next_bright  = RCSD_BRIGHT_OFF;
    end
    if (flash && in_normal && !syncing) begin
      next_bright = RCSD_BRIGHT_FULL;
    end
    if (next_bright == RCSD_BRIGHT_OFF) begin
      next_blank = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_content <= rcsd_show_status;
      disp_blank   <= 1'b1;
      disp_dp      <= 1'b0;
      disp_bright  <= RCSD_BRIGHT_OFF;
      disp_status  <= rcsd_no_signal;
      rx_led       <= 1'b0;
    end else begin
      disp_content <= next_content;
      disp_blank   <= next_blank;
      disp_dp      <= next_dp;
      disp_bright  <= next_bright;
      disp_status  <= sync_state;
      rx_led       <= led_en & rx_pulse;
    end
  end
endmodule : rcsd_top
`default_nettype wire

// File: common/rcsd_pkg.sv
package rcsd_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] RCSD_OFF_CTRL   = 8'h00;
  localparam logic [7:0] RCSD_OFF_BRIGHT = 8'h04;
  localparam logic [7:0] RCSD_OFF_STATUS = 8'h08;
  // ==========================================
  // ctrl field layout
  localparam int RCSD_CTRL_RXB_LSB  = 0;
  localparam int RCSD_CTRL_MODE_LSB = 5;
  localparam int RCSD_CTRL_LED_BIT  = 7;
  localparam int RCSD_CTRL_TEMP_BIT = 8;
  localparam int RCSD_CTRL_ALT_LSB  = 16;
  // ==========================================
  // status field layout
  localparam int RCSD_ST_SYNC_LSB  = 0;
  localparam int RCSD_ST_ALARM_BIT = 2;
  localparam int RCSD_ST_FLASH_BIT = 3;
  localparam int RCSD_ST_MAIN_LSB  = 4;
  localparam int RCSD_ST_SUB_LSB   = 8;
  localparam int RCSD_ST_INSUB_BIT = 12;
  localparam int RCSD_ST_BRT_LSB   = 16;
  localparam int RCSD_ST_SEC_LSB   = 24;
  // ==========================================
  // widths, reset values, counts
  localparam int          RCSD_BW            = 5;
  localparam int          RCSD_MW            = 4;
  localparam logic [4:0]  RCSD_BRIGHT_FULL   = 5'h19;
  localparam logic [4:0]  RCSD_BRIGHT_OFF    = 5'h00;
  localparam logic [4:0]  RCSD_RST_RXBRIGHT  = 5'h0F;
  localparam logic [4:0]  RCSD_RST_BRIGHT    = 5'h19;
  localparam logic [7:0]  RCSD_RST_ALT_SECS  = 8'h05;
  localparam int          RCSD_READ_SECONDS  = 60;
  localparam int          RCSD_MAIN_ENTRIES  = 9;
  // normal entry, main menu entries owning a submenu and their item counts
  localparam logic [3:0]  RCSD_MAIN_NORMAL   = 4'h0;
  localparam logic [3:0]  RCSD_MAIN_ALARM    = 4'h2;
  localparam logic [3:0]  RCSD_MAIN_BRIGHT   = 4'h3;
  localparam logic [3:0]  RCSD_MAIN_DCF      = 4'h4;
  localparam logic [3:0]  RCSD_MAIN_CLOCK    = 4'h5;
  localparam logic [3:0]  RCSD_ITEMS_ALARM   = 4'h8;
  localparam logic [3:0]  RCSD_ITEMS_BRIGHT  = 4'hC;
  localparam logic [3:0]  RCSD_ITEMS_DCF     = 4'h9;
  localparam logic [3:0]  RCSD_ITEMS_CLOCK   = 4'h9;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    show_nothing_mode,
    show_time_only_mode,
    show_date_only_mode,
    show_alternating_mode
  } rcsd_mode_t;
  typedef enum logic [1:0] {
    rcsd_no_signal,
    rcsd_searching,
    status_decoding,
    rcsd_synced
  } rcsd_sync_t;
  typedef enum logic [2:0] {
    rcsd_show_status,
    rcsd_show_time,
    rcsd_show_date,
    rcsd_show_temp,
    rcsd_show_dashes,
    rcsd_show_menu
  } rcsd_content_t;
endpackage : rcsd_pkg

// File: src/rcsd_edge.sv
`timescale 1ns/1ps
`default_nettype none
module rcsd_edge #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels in, one-cycle rise pulses out
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] rise
);
  logic [N-1:0] prev;

  // ==========================================
  // per-bit rise detector
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev[g] <= 1'b0;
        end else begin
          prev[g] <= level[g];
        end
      end
      assign rise[g] = level[g] & ~prev[g];
    end
  endgenerate
endmodule : rcsd_edge
`default_nettype wire

// File: sim/rcsd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rcsd_checker
  import rcsd_pkg::*;
#(
  parameter int BRIGHT_LEVELS = 26
) (
  // clock and reset
  input wire logic                         pclk,
  input wire logic                         presetn,
  // receiver and buttons
  input wire logic                         rx_clean,
  input wire logic                         rx_pulse,
  input wire logic                         rx_minute_mark,
  input wire logic                         btn_plus,
  input wire logic                         btn_step,
  // display and menu
  input wire logic                         rx_led,
  input wire logic                         disp_blank,
  input wire rcsd_pkg::rcsd_sync_t         disp_status,
  input wire logic [rcsd_pkg::RCSD_BW-1:0] disp_bright,
  input wire logic                         alarm_on,
  input wire logic [rcsd_pkg::RCSD_MW-1:0] menu_main,
  input wire logic [rcsd_pkg::RCSD_MW-1:0] menu_item,
  input wire logic                         menu_in_sub
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // sync status
  // state moves on the edge, status shows one edge later
  a_search_start: assert property (
    disp_status == rcsd_no_signal && rx_clean && !rx_minute_mark
    |-> ##2 disp_status == rcsd_searching) else $error("search not entered");
  a_mark_decode: assert property (
    disp_status == rcsd_searching && rx_clean && rx_minute_mark
    |-> ##2 disp_status == status_decoding) else $error("decoding not entered");
  a_signal_lost: assert property (
    disp_status inside {rcsd_searching, status_decoding} && !rx_clean
    |-> ##2 disp_status == rcsd_no_signal) else $error("loss not seen");
  a_led_follow: assert property (
    rx_led |-> $past(rx_pulse)) else $error("led without pulse");
  a_dark_blank: assert property (
    disp_bright == RCSD_BRIGHT_OFF |-> disp_blank) else $error("lit at level 0");
  // ==========================================
  // buttons and menu
  a_plus_toggle: assert property (
    $rose(btn_plus) && menu_main == RCSD_MAIN_NORMAL && !menu_in_sub
    |-> ##[1:3] alarm_on != $past(alarm_on)) else $error("alarm not toggled");
  a_main_wrap: assert property (
    $rose(btn_step) && !menu_in_sub && menu_main == 4'h8
    |-> ##[1:3] menu_main == 4'h0) else $error("main menu no wrap");
  a_item_wrap: assert property (
    $rose(btn_step) && menu_in_sub && menu_main == RCSD_MAIN_ALARM && menu_item == 4'h7
    |-> ##[1:3] menu_item == 4'h0) else $error("submenu no wrap");
  c_synced: cover property (disp_status == rcsd_synced);
  c_sub: cover property (menu_in_sub);
  c_alarm: cover property (alarm_on);
endmodule : rcsd_checker
bind rcsd_top rcsd_checker #(.BRIGHT_LEVELS(BRIGHT_LEVELS)) chk_u (
  .pclk, .presetn, .rx_clean, .rx_pulse, .rx_minute_mark, .btn_plus, .btn_step,
  .rx_led, .disp_blank, .disp_status, .disp_bright, .alarm_on, .menu_main,
  .menu_item, .menu_in_sub);
`default_nettype wire

// File: sim/rcsd_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcsd_rx_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench control, half sets prompt or slow seconds
  input  wire logic       clean_req,
  input  wire logic       mark_req,
  input  wire logic       pulse_go,
  input  wire logic [3:0] half,
  // receiver lines
  output logic            rx_clean,
  output logic            rx_pulse,
  output logic            rx_minute_mark,
  output int              rises
);
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_clean, rx_pulse, rx_minute_mark, cnt} <= '0;
      rises <= 0;
    end else begin
      rx_clean <= clean_req;
      // marker only exists on a clean signal
      rx_minute_mark <= clean_req & mark_req;
      cnt <= (pulse_go && cnt >= half) ? 4'h0 : cnt + 4'h1;
      if (pulse_go && cnt >= half) begin
        rx_pulse <= ~rx_pulse;
        rises <= rises + (rx_pulse ? 0 : 1);
      end
    end
  end
endmodule : rcsd_rx_model
`default_nettype wire

// File: sim/test_radio_clock_sync_display_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_radio_clock_sync_display_control;
  import rcsd_pkg::*;
  // ==========================================
  // signals
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, sec_tick;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdv;
  logic [2:0]    btn;
  logic [3:0]    half, menu_main, menu_item;
  logic [4:0]    disp_bright;
  logic          clean_req, mark_req, pulse_go, rx_clean, rx_pulse, rx_mark, erv;
  logic          rx_led, disp_blank, disp_dp, alarm_on, menu_in_sub;
  rcsd_content_t disp_content;
  rcsd_sync_t    disp_status;
  int            rises, err_total, compares, n, r, m_main, lit;
  rcsd_content_t mexp[4] = '{rcsd_show_dashes, rcsd_show_time, rcsd_show_date, rcsd_show_time};
  rcsd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_clean, .rx_pulse, .rx_minute_mark(rx_mark), .sec_tick,
    .btn_plus(btn[0]), .btn_minus(btn[1]), .btn_step(btn[2]), .rx_led, .disp_blank,
    .disp_dp, .disp_content, .disp_status, .disp_bright, .alarm_on, .menu_main,
    .menu_item, .menu_in_sub);
  rcsd_rx_model rx_u (.pclk, .presetn, .clean_req, .mark_req, .pulse_go, .half,
    .rx_clean, .rx_pulse, .rx_minute_mark(rx_mark), .rises);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) sec_tick <= ($urandom_range(0, 49) == 0);
  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (k == 50) err_total++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rdv, exp);
  endtask : rd_chk
  task automatic settle(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic press(input int b);
    btn[b] <= 1'b1;
    repeat (3) @(posedge pclk);
    btn[b] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : press
  task automatic wait_st(input rcsd_sync_t s);
    int k;
    k = 0;
    while (disp_status !== s && k < 3000) begin
      k++;
      @(posedge pclk);
    end
    chk("status", disp_status, s);
  endtask : wait_st
  task automatic led_cnt(input logic en);
    logic p;
    p = rx_pulse;
    n = 0;
    lit = 0;
    repeat (40) begin
      @(posedge pclk);
      n += (rx_led !== (en & p));
      lit += (rx_led === 1'b1);
      p = rx_pulse;
    end
  endtask : led_cnt
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
  // ==========================================
  // tests
  initial begin
    {psel, penable, pwrite, paddr, pwdata, btn} = '0;
    {clean_req, mark_req, pulse_go, half} = '0;
    {presetn, err_total, compares} = '0;
    void'($urandom(32'h8D1134C3));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk("ctrl", RCSD_OFF_CTRL, 32'h0005_00EF);
    rd_chk("bright", RCSD_OFF_BRIGHT, 32'h0000_0019);
    rd_chk("stat", RCSD_OFF_STATUS, 32'h000F_0000);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", {rdv[30:0], erv}, 32'h1);
    apb(1'b1, RCSD_OFF_STATUS, 32'hFFFF_FFFF);
    chk("ro", erv, 32'h1);
    settle(RCSD_OFF_BRIGHT, 32'h1F);
    rd_chk("clamp", RCSD_OFF_BRIGHT, 32'h19);
    chk("text", {disp_content, disp_bright}, {rcsd_show_status, 5'h0F});
    $display("test registers done");
    // lost signal mid-decode, then a full minute
    clean_req <= 1'b1;
    half <= 4'($urandom_range(0, 3));
    wait_st(rcsd_searching);
    mark_req <= 1'b1;
    wait_st(status_decoding);
    mark_req <= 1'b0;
    pulse_go <= 1'b1;
    repeat (40) @(posedge pclk);
    clean_req <= 1'b0;
    wait_st(rcsd_no_signal);
    pulse_go <= 1'b0;
    clean_req <= 1'b1;
    mark_req <= 1'b1;
    wait_st(status_decoding);
    mark_req <= 1'b0;
    chk("lit", {disp_blank, disp_content}, {1'b0, rcsd_show_status});
    half <= 4'h7;
    pulse_go <= 1'b1;
    r = rises + 59;
    while (rises < r) @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk("early", disp_status, status_decoding);
    wait_st(rcsd_synced);
    led_cnt(1'b1);
    chk("led follow", n, 32'h0);
    chk("led on", lit > 0, 32'h1);
    $display("test sync done");
    for (int m = 0; m < 4; m++) begin
      settle(RCSD_OFF_CTRL, 32'h0005_000F | (m << 5));
      chk("mode", disp_content, mexp[m]);
    end
    n = 0;
    while (disp_content !== rcsd_show_date && n < 2000) begin
      n++;
      @(posedge pclk);
    end
    chk("alternate", disp_content, rcsd_show_date);
    led_cnt(1'b0);
    chk("led follow", n, 32'h0);
    chk("led off", lit, 32'h0);
    settle(RCSD_OFF_CTRL, 32'h0005_010F);
    chk("temp", disp_content, rcsd_show_temp);
    r = $urandom_range(1, 24);
    settle(RCSD_OFF_BRIGHT, r);
    chk("level", {disp_blank, disp_bright}, r);
    settle(RCSD_OFF_BRIGHT, 32'h0);
    chk("off", {disp_blank, disp_bright}, 32'h20);
    settle(RCSD_OFF_BRIGHT, r);
    $display("test display done");
    for (int i = 1; i < 3; i++) begin
      press(0);
      chk("alarm", alarm_on, i % 2);
      press(1);
      chk("flash", disp_bright, (i == 1) ? 25 : r);
    end
    m_main = 0;
    for (int i = 0; i < 11; i++) begin
      press(2);
      m_main = (m_main + 1) % RCSD_MAIN_ENTRIES;
      chk("main", menu_main, m_main);
      chk("view", disp_content, (m_main == 0) ? rcsd_show_temp : rcsd_show_menu);
    end
    press(0);
    for (int i = 1; i < 9; i++) begin
      chk("item", {menu_in_sub, menu_item}, {1'b1, 4'(i - 1)});
      press(2);
    end
    chk("wrap", menu_item, 32'h0);
    press(1);
    chk("leave", menu_in_sub, 32'h0);
    $display("test buttons done");
    {clean_req, pulse_go} <= 2'b00;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    settle(RCSD_OFF_CTRL, 32'h0005_00E0);
    chk("dark", {disp_blank, disp_dp, disp_bright}, 32'h60);
    clean_req <= 1'b1;
    wait_st(rcsd_searching);
    chk("dark sync", {disp_blank, disp_dp, disp_bright}, 32'h60);
    $display("test dark done");
    print_verdict();
  end
endmodule : test_radio_clock_sync_display_control
`default_nettype wire
